// [hdl/evs_params.svh]
// Constants of the event status and temperature readout bank
//
// Behaviour
// - Set a port's conversion-ready flag when fresh result data is written.
// - With averaging, result and flag update only after the full sample group.
// - Conversion-ready flags record regardless of any interrupt mask.
// - Conversion flags clear after summary read, then both status reads.
// - Ports 0-5 at bits 7:2, 6-10 at 15:11; port 11 at bit 0.
// - Set a per-port flag when that driver exceeds its current limit.
// - Overcurrent flags record regardless of any interrupt mask.
// - Overcurrent flags clear after summary read, then both status reads.
// - Internal temperature is 12-bit two's complement, 0.125 C per count.
// - Remote sensor 1 temperature is 12-bit two's complement, 0.125 C/count.
// - Remote sensor 2 temperature is 12-bit two's complement, 0.125 C/count.
// - Set input-event flag when the selected edge hits a digital-input port.
// - Input-event flags record regardless of any interrupt mask.
// - Input-event flags clear after summary read, then both status reads.
// - Input-event flags use the same bit layout as conversion flags.
// - Edge code 00 never, 01 rising, 10 falling, 11 either edge.
`ifndef EVS_PARAMS_SVH
`define EVS_PARAMS_SVH

// -----------------------------------------------------------------------
// Sizes
// -----------------------------------------------------------------------
`define EVS_PORTS        12
`define EVS_ADDR_W       4
`define EVS_DATA_W       16
`define EVS_TEMP_W       12
`define EVS_AVG_W        3
`define EVS_CNT_W        7

// -----------------------------------------------------------------------
// Register indices on the read port
// -----------------------------------------------------------------------
`define EVS_ADDR_CONV_LO 4'h0
`define EVS_ADDR_CONV_HI 4'h1
`define EVS_ADDR_OC_LO   4'h2
`define EVS_ADDR_OC_HI   4'h3
`define EVS_ADDR_T_INT   4'h4
`define EVS_ADDR_T_REM1  4'h5
`define EVS_ADDR_T_REM2  4'h6
`define EVS_ADDR_GPI_LO  4'h7
`define EVS_ADDR_GPI_HI  4'h8

// -----------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------
`define EVS_GRP_A_LSB    2
`define EVS_GRP_A_N      6
`define EVS_GRP_B_LSB    11
`define EVS_GRP_B_N      5
`define EVS_P11_BIT      0
`define EVS_P11_PORT     11
`define EVS_FLAGS_RST    12'h000
`define EVS_TEMP_RST     12'h000
`define EVS_DATA_RST     16'h0000

// -----------------------------------------------------------------------
// Edge select codes
// -----------------------------------------------------------------------
`define EVS_EDGE_NONE    2'h0
`define EVS_EDGE_RISE    2'h1
`define EVS_EDGE_FALL    2'h2
`define EVS_EDGE_BOTH    2'h3

`endif

// [hdl/evs_pkg.sv]
// Types shared by the event status and temperature readout bank
`default_nettype none
`include "evs_params.svh"

package evs_pkg;

  typedef logic [`EVS_PORTS-1:0]   evs_flags_t;
  typedef logic [`EVS_TEMP_W-1:0]  evs_temp_t;
  typedef logic [`EVS_DATA_W-1:0]  evs_data_t;
  typedef logic [`EVS_ADDR_W-1:0]  evs_addr_t;

  // Progress of one clear sequence
  typedef struct packed {
    logic armed;
    logic seen_lo;
    logic seen_hi;
  } evs_clr_t;

endpackage

`default_nettype wire

// [hdl/evs_conv_if.sv]
// Carrier between the top and the averaging gate
`default_nettype none
`include "evs_params.svh"

interface evs_conv_if;
  logic [`EVS_PORTS-1:0]              sample;
  logic [`EVS_PORTS*`EVS_AVG_W-1:0]   avg_log2;
  logic [`EVS_PORTS-1:0]              written;

  modport src  (output sample, output avg_log2, input written);
  modport gate (input sample, input avg_log2, output written);
endinterface

`default_nettype wire

// [hdl/evs_avg_gate.sv]
// Per-port averaging gate: one result write per full group of samples
`default_nettype none
`include "evs_params.svh"

module evs_avg_gate #(
  parameter int PORTS = `EVS_PORTS
) (
  input  wire logic   clk_i,    // Device clock
  input  wire logic   rst_n_i,  // Synchronised reset, active low
  evs_conv_if.gate    cv        // Samples in, result writes out
);
  import evs_pkg::*;

  typedef struct packed {
    logic [PORTS-1:0][`EVS_CNT_W-1:0] cnt;
    logic [PORTS-1:0]                 written;
  } evs_gate_state_t;

  evs_gate_state_t st;
  evs_gate_state_t next_st;

  // Count samples; the result write comes only at the group's end
  always_comb begin
    logic [`EVS_CNT_W-1:0] last;
    last    = '0;
    next_st = st;
    next_st.written = '0;
    for (int p = 0; p < PORTS; p++) begin
      last = `EVS_CNT_W'((8'h01 << cv.avg_log2[p*`EVS_AVG_W +: `EVS_AVG_W])
                         - 8'h01);
      if (cv.sample[p]) begin
        if (st.cnt[p] >= last) begin
          next_st.cnt[p]     = '0;
          next_st.written[p] = 1'b1;
        end else begin
          next_st.cnt[p] = st.cnt[p] + `EVS_CNT_W'(1);
        end
      end
    end
  end

  // Registered state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cv.written = st.written;

endmodule

`default_nettype wire

// [hdl/evs_bank.sv]
// Event status flags and temperature readout register bank
`default_nettype none
`include "evs_params.svh"

module evs_bank (
  input  wire logic                 mclk_i,          // Device clock
  input  wire logic                 reset_n_i,       // Async reset, low
  // Read port from the serial front end
  input  wire logic                 rd_en_i,         // Read strobe
  input  wire evs_pkg::evs_addr_t   rd_addr_i,       // Register index
  output logic                      rd_valid_o,      // Read data valid
  output evs_pkg::evs_data_t        rd_data_o,       // Read data
  input  wire logic                 summary_read_i,  // Summary reg read
  // Converter side
  input  wire evs_pkg::evs_flags_t  conv_sample_i,   // Sample done/port
  input  wire logic [`EVS_PORTS*`EVS_AVG_W-1:0]
                                    avg_log2_i,      // Log2 group size
  // Driver and input pins
  input  wire evs_pkg::evs_flags_t  oc_detect_i,     // Overcurrent comp
  input  wire evs_pkg::evs_flags_t  gpi_pin_i,       // Input port levels
  input  wire evs_pkg::evs_flags_t  port_is_gpi_i,   // Port is input
  input  wire logic [2*`EVS_PORTS-1:0]
                                    input_edge_select_i, // Edge codes
  // Temperature sensors
  input  wire evs_pkg::evs_temp_t   temp_int_i,      // Internal reading
  input  wire logic                 temp_int_vld_i,  // Internal update
  input  wire evs_pkg::evs_temp_t   temp_rem1_i,     // Remote 1 reading
  input  wire logic                 temp_rem1_vld_i, // Remote 1 update
  input  wire evs_pkg::evs_temp_t   temp_rem2_i,     // Remote 2 reading
  input  wire logic                 temp_rem2_vld_i, // Remote 2 update
  // Summary levels toward the interrupt logic
  output logic                      conv_any_o,      // Any conv flag
  output logic                      oc_any_o,        // Any overcurrent
  output logic                      gpi_any_o        // Any input event
);
  import evs_pkg::*;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  typedef struct packed {
    evs_flags_t gpi_s1;
    evs_flags_t gpi_s2;
    evs_flags_t gpi_prev;
    evs_flags_t oc_s1;
    evs_flags_t oc_s2;
    evs_flags_t conv_flags;
    evs_flags_t oc_flags;
    evs_flags_t gpi_flags;
    evs_clr_t   conv_clr;
    evs_clr_t   oc_clr;
    evs_clr_t   gpi_clr;
    evs_temp_t  t_int;
    evs_temp_t  t_rem1;
    evs_temp_t  t_rem2;
    evs_data_t  rd_data;
    logic       rd_valid;
    logic       conv_any;
    logic       oc_any;
    logic       gpi_any;
  } evs_bank_state_t;

  evs_bank_state_t st;
  evs_bank_state_t next_st;

  logic [1:0] rst_pipe;
  logic       rst_n;

  // -----------------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------------
  // Assert at once, release two edges later so all state leaves together
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // -----------------------------------------------------------------------
  // Averaging gate
  // -----------------------------------------------------------------------
  evs_conv_if cv ();
  assign cv.sample   = conv_sample_i;
  assign cv.avg_log2 = avg_log2_i;

  evs_avg_gate #(
    .PORTS (`EVS_PORTS)
  ) u_gate (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .cv      (cv)
  );

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Spread ports 0-10 over the low status word
  function automatic evs_data_t pack_lo(input evs_flags_t f);
    evs_data_t v;
    v = '0;
    for (int i = 0; i < `EVS_GRP_A_N; i++) begin
      v[`EVS_GRP_A_LSB + i] = f[i];
    end
    for (int i = 0; i < `EVS_GRP_B_N; i++) begin
      v[`EVS_GRP_B_LSB + i] = f[`EVS_GRP_A_N + i];
    end
    return v;
  endfunction

  // Port 11 alone in the second word
  function automatic evs_data_t pack_hi(input evs_flags_t f);
    evs_data_t v;
    v = '0;
    v[`EVS_P11_BIT] = f[`EVS_P11_PORT];
    return v;
  endfunction

  // Temperatures sit in the low bits, reserved bits read zero
  function automatic evs_data_t pack_temp(input evs_temp_t t);
    return {{(`EVS_DATA_W-`EVS_TEMP_W){1'b0}}, t};
  endfunction

  // Clear sequence is complete with this cycle's reads included
  function automatic logic clr_done(input evs_clr_t c, input logic arm,
                                    input logic rlo, input logic rhi);
    return !arm && c.armed && (c.seen_lo || rlo) && (c.seen_hi || rhi);
  endfunction

  // Next step of a clear sequence; a new summary read restarts it
  function automatic evs_clr_t clr_step(input evs_clr_t c, input logic arm,
                                        input logic rlo, input logic rhi);
    evs_clr_t n;
    n = c;
    if (arm) begin
      n = '{armed: 1'b1, seen_lo: 1'b0, seen_hi: 1'b0};
    end else if (clr_done(c, arm, rlo, rhi)) begin
      n = '0;
    end else if (c.armed) begin
      n.seen_lo = c.seen_lo || rlo;
      n.seen_hi = c.seen_hi || rhi;
    end
    return n;
  endfunction

  // Edge match for one port's two-bit select code
  function automatic logic edge_hit(input logic [1:0] code,
                                    input logic now, input logic was);
    logic r;
    r = 1'b0;
    case (code)
      `EVS_EDGE_NONE: r = 1'b0;
      `EVS_EDGE_RISE: r = now && !was;
      `EVS_EDGE_FALL: r = !now && was;
      default:        r = now != was;
    endcase
    return r;
  endfunction

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    logic       rd_cl;
    logic       rd_ch;
    logic       rd_ol;
    logic       rd_oh;
    logic       rd_gl;
    logic       rd_gh;
    evs_flags_t gpi_ev;
    rd_cl  = 1'b0;
    rd_ch  = 1'b0;
    rd_ol  = 1'b0;
    rd_oh  = 1'b0;
    rd_gl  = 1'b0;
    rd_gh  = 1'b0;
    gpi_ev = '0;
    next_st = st;

    // Pins cross in through two flops before anything looks at them
    next_st.gpi_s1   = gpi_pin_i;
    next_st.gpi_s2   = st.gpi_s1;
    next_st.gpi_prev = st.gpi_s2;
    next_st.oc_s1    = oc_detect_i;
    next_st.oc_s2    = st.oc_s1;

    // Address decode; unmapped indices answer zero
    next_st.rd_valid = rd_en_i;
    if (rd_en_i) begin
      if (rd_addr_i == `EVS_ADDR_CONV_LO) begin
        rd_cl = 1'b1;
        next_st.rd_data = pack_lo(st.conv_flags);
      end else if (rd_addr_i == `EVS_ADDR_CONV_HI) begin
        rd_ch = 1'b1;
        next_st.rd_data = pack_hi(st.conv_flags);
      end else if (rd_addr_i == `EVS_ADDR_OC_LO) begin
        rd_ol = 1'b1;
        next_st.rd_data = pack_lo(st.oc_flags);
      end else if (rd_addr_i == `EVS_ADDR_OC_HI) begin
        rd_oh = 1'b1;
        next_st.rd_data = pack_hi(st.oc_flags);
      end else if (rd_addr_i == `EVS_ADDR_T_INT) begin
        next_st.rd_data = pack_temp(st.t_int);
      end else if (rd_addr_i == `EVS_ADDR_T_REM1) begin
        next_st.rd_data = pack_temp(st.t_rem1);
      end else if (rd_addr_i == `EVS_ADDR_T_REM2) begin
        next_st.rd_data = pack_temp(st.t_rem2);
      end else if (rd_addr_i == `EVS_ADDR_GPI_LO) begin
        rd_gl = 1'b1;
        next_st.rd_data = pack_lo(st.gpi_flags);
      end else if (rd_addr_i == `EVS_ADDR_GPI_HI) begin
        rd_gh = 1'b1;
        next_st.rd_data = pack_hi(st.gpi_flags);
      end else begin
        next_st.rd_data = `EVS_DATA_RST;
      end
    end

    // Sequence trackers: summary read, then both halves in any order
    next_st.conv_clr = clr_step(st.conv_clr, summary_read_i,
                                rd_cl, rd_ch);
    next_st.oc_clr   = clr_step(st.oc_clr, summary_read_i,
                                rd_ol, rd_oh);
    next_st.gpi_clr  = clr_step(st.gpi_clr, summary_read_i,
                                rd_gl, rd_gh);

    // Clear first, then OR in this cycle's events so none is lost
    if (clr_done(st.conv_clr, summary_read_i, rd_cl, rd_ch)) begin
      next_st.conv_flags = `EVS_FLAGS_RST;
    end
    if (clr_done(st.oc_clr, summary_read_i, rd_ol, rd_oh)) begin
      next_st.oc_flags = `EVS_FLAGS_RST;
    end
    if (clr_done(st.gpi_clr, summary_read_i, rd_gl, rd_gh)) begin
      next_st.gpi_flags = `EVS_FLAGS_RST;
    end

    // No mask reaches these flags; masking lives in the interrupt logic
    next_st.conv_flags = next_st.conv_flags | cv.written;
    next_st.oc_flags   = next_st.oc_flags | st.oc_s2;
    for (int p = 0; p < `EVS_PORTS; p++) begin
      gpi_ev[p] = port_is_gpi_i[p]
                  && edge_hit(input_edge_select_i[2*p +: 2],
                              st.gpi_s2[p], st.gpi_prev[p]);
    end
    next_st.gpi_flags  = next_st.gpi_flags | gpi_ev;

    // Temperature results latch on their update strobes
    if (temp_int_vld_i) begin
      next_st.t_int = temp_int_i;
    end
    if (temp_rem1_vld_i) begin
      next_st.t_rem1 = temp_rem1_i;
    end
    if (temp_rem2_vld_i) begin
      next_st.t_rem2 = temp_rem2_i;
    end

    // Summary levels follow the flags one cycle behind
    next_st.conv_any = |st.conv_flags;
    next_st.oc_any   = |st.oc_flags;
    next_st.gpi_any  = |st.gpi_flags;
  end

  // -----------------------------------------------------------------------
  // Registered state
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign rd_valid_o = st.rd_valid;
  assign rd_data_o  = st.rd_data;
  assign conv_any_o = st.conv_any;
  assign oc_any_o   = st.oc_any;
  assign gpi_any_o  = st.gpi_any;

endmodule

`default_nettype wire

// [tb/evs_bank_chk.sv]
// Port-level checker for the event status and temperature bank
`default_nettype none
`include "evs_params.svh"

module evs_bank_chk (
  input wire logic                mclk_i,          // Device clock
  input wire logic                reset_n_i,       // Async reset, low
  input wire logic                rd_en_i,         // Read strobe
  input wire evs_pkg::evs_addr_t  rd_addr_i,       // Register index
  input wire logic                rd_valid_o,      // Read data valid
  input wire evs_pkg::evs_data_t  rd_data_o,       // Read data
  input wire evs_pkg::evs_flags_t conv_sample_i,   // Sample pulses
  input wire evs_pkg::evs_flags_t gpi_pin_i,       // Input levels
  input wire evs_pkg::evs_temp_t  temp_int_i,      // Internal reading
  input wire logic                temp_int_vld_i,  // Internal update
  input wire evs_pkg::evs_temp_t  temp_rem1_i,     // Remote 1 reading
  input wire logic                temp_rem1_vld_i, // Remote 1 update
  input wire logic                summary_read_i,  // Summary read
  input wire logic                conv_any_o,      // Any conv flag
  input wire logic                oc_any_o,        // Any overcurrent
  input wire logic                gpi_any_o        // Any input event
);
  timeunit 1ns;
  timeprecision 1ps;
  import evs_pkg::*;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // ---------------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------------
  logic [3:0] s_age;
  logic [3:0] p_age;
  evs_flags_t pin_q;
  evs_temp_t  t_int;
  evs_temp_t  t_r1;

  // Ages saturate so a long quiet spell never wraps back to small values
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_age <= 4'hF;
      p_age <= 4'hF;
      pin_q <= '0;
      t_int <= '0;
      t_r1  <= '0;
    end else begin
      s_age <= (|conv_sample_i) ? 4'h0 : s_age + {3'h0, s_age != 4'hF};
      p_age <= (gpi_pin_i != pin_q) ? 4'h0 : p_age + {3'h0, p_age != 4'hF};
      pin_q <= gpi_pin_i;
      if (temp_int_vld_i) t_int <= temp_int_i;
      if (temp_rem1_vld_i) t_r1 <= temp_rem1_i;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  a_read_answer: assert property (rd_en_i |=> rd_valid_o)
    else $error("read strobe not answered next cycle");
  a_no_spurious_valid: assert property (!rd_en_i |=> !rd_valid_o)
    else $error("read valid without a read");
  a_unmapped_zero: assert property
    (rd_en_i && rd_addr_i > 4'h8 |=> rd_data_o == 16'h0000)
    else $error("unmapped index returned data");
  a_temp_int_value: assert property
    (rd_en_i && rd_addr_i == 4'h4 && !temp_int_vld_i
     |=> rd_data_o == {4'h0, $past(t_int)})
    else $error("internal temperature word wrong");
  a_temp_rem1_value: assert property
    (rd_en_i && rd_addr_i == 4'h5 && !temp_rem1_vld_i
     |=> rd_data_o == {4'h0, $past(t_r1)})
    else $error("remote 1 temperature word wrong");
  a_flag_hi_layout: assert property
    (rd_en_i && (rd_addr_i == 4'h1 || rd_addr_i == 4'h3 || rd_addr_i == 4'h8)
     |=> rd_data_o[15:1] == 15'h0000)
    else $error("high status word has stray bits");
  a_flag_lo_layout: assert property
    (rd_en_i && (rd_addr_i == 4'h0 || rd_addr_i == 4'h2 || rd_addr_i == 4'h7)
     |=> rd_data_o[10:8] == 3'h0 && rd_data_o[1:0] == 2'h0)
    else $error("low status word has stray bits");
  a_conv_sticky: assert property
    (conv_any_o && !rd_en_i && !$past(rd_en_i) && !$past(rd_en_i, 2)
     |=> conv_any_o)
    else $error("conversion flags dropped without a read");
  a_oc_sticky: assert property
    (oc_any_o && !rd_en_i && !$past(rd_en_i) && !$past(rd_en_i, 2)
     |=> oc_any_o)
    else $error("overcurrent flags dropped without a read");
  a_gpi_sticky: assert property
    (gpi_any_o && !rd_en_i && !$past(rd_en_i) && !$past(rd_en_i, 2)
     |=> gpi_any_o)
    else $error("input event flags dropped without a read");
  a_conv_cause: assert property ($rose(conv_any_o) |-> s_age <= 4'h4)
    else $error("conversion flag rose without a sample");
  a_gpi_cause: assert property ($rose(gpi_any_o) |-> p_age <= 4'h8)
    else $error("input event flag rose without a pin change");

  // Main scenarios reached
  c_clear_seq: cover property (summary_read_i ##1 rd_en_i);
  c_conv_drop: cover property (conv_any_o ##1 !conv_any_o);
  c_gpi_event: cover property ($rose(gpi_any_o));
endmodule

bind evs_bank evs_bank_chk u_evs_bank_chk (.*);

`default_nettype wire

// [tb/evs_host.sv]
// Host model: serial front end reaching the bank's read port
`default_nettype none

module evs_host
  import evs_pkg::*;
(
  input  wire logic  clk_i,      // Device clock
  input  wire logic  rd_valid_i, // Read answer valid
  input  wire evs_data_t rd_data_i,  // Read answer data
  output logic       rd_en_o,    // Read strobe
  output evs_addr_t  rd_addr_o,  // Register index
  output logic       summary_o   // Summary register read
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = '0;
    summary_o = 1'b0;
  end

  // One read: strobe for one edge, answer taken while valid stands
  task automatic rd(input evs_addr_t a, output evs_data_t d,
                    output logic v);
    @(negedge clk_i);
    rd_en_o   = 1'b1;
    rd_addr_o = a;
    @(negedge clk_i);
    v = rd_valid_i; // Valid stands for one cycle only
    d = rd_data_i;
    rd_en_o   = 1'b0;
    rd_addr_o = ~a; // Released index never keeps its last value
  endtask

  // Summary read then both words of one status pair
  task automatic clear_pair(input evs_addr_t lo, input evs_addr_t hi);
    evs_data_t d;
    logic      v;
    @(negedge clk_i);
    summary_o = 1'b1;
    @(negedge clk_i);
    summary_o = 1'b0;
    rd(lo, d, v);
    rd(hi, d, v);
  endtask
endmodule

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the event status and temperature bank
`default_nettype none
`include "evs_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import evs_pkg::*;

  logic        mclk, reset_n, rd_en, summ, rd_valid;
  logic        conv_any, oc_any, gpi_any, v_int, v_r1, v_r2;
  evs_addr_t   rd_addr;
  evs_data_t   rd_data;
  evs_flags_t  conv_s, oc_det, pins, is_gpi;
  logic [35:0] avg;
  logic [23:0] edge_sel;
  evs_temp_t   t_int, t_r1, t_r2;
  int          miscompares, checks_done;

  evs_bank u_evs_bank (.mclk_i(mclk), .reset_n_i(reset_n),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .summary_read_i(summ), .conv_sample_i(conv_s),
    .avg_log2_i(avg), .oc_detect_i(oc_det), .gpi_pin_i(pins),
    .port_is_gpi_i(is_gpi), .input_edge_select_i(edge_sel),
    .temp_int_i(t_int), .temp_int_vld_i(v_int), .temp_rem1_i(t_r1),
    .temp_rem1_vld_i(v_r1), .temp_rem2_i(t_r2), .temp_rem2_vld_i(v_r2),
    .conv_any_o(conv_any), .oc_any_o(oc_any), .gpi_any_o(gpi_any));

  evs_host u_evs_host (.clk_i(mclk), .rd_valid_i(rd_valid),
    .rd_data_i(rd_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .summary_o(summ));

  // -----------------------------------------------------------------------
  // Clock, checks and closing
  // -----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input string nm, input evs_data_t exp,
                     input evs_data_t got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input evs_addr_t a, input evs_data_t exp,
                       input string nm);
    evs_data_t d;
    logic      v;
    u_evs_host.rd(a, d, v);
    chk({nm, " valid"}, 16'h0001, {15'h0000, v});
    chk(nm, exp, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One-cycle sample pulse on the given ports
  task automatic pulse(input evs_flags_t m);
    @(negedge mclk);
    conv_s = m;
    @(negedge mclk);
    conv_s = '0;
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is under two hundred cycles; this leaves ample slack
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end

  // -----------------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------------
  initial begin
    reset_n = 1'b0; conv_s = '0; oc_det = '0; pins = '0;
    avg = 36'h000000400;    // Port 3 averages four samples
    is_gpi = 12'h80F;       // Ports 0-3 and 11 are inputs, port 4 is not
    edge_sel = 24'h4003E4;  // Ports 0-3 codes 00..11, port 4 11, port 11 01
    t_int = '0; t_r1 = '0; t_r2 = '0; v_int = 0; v_r1 = 0; v_r2 = 0;
    miscompares = 0; checks_done = 0;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    idle(4);
    for (int a = 0; a < 16; a++)
      rdchk(a[3:0], 16'h0000, "reset word");
    // Latched temperatures, then inputs move away
    @(negedge mclk);
    t_int = 12'h800; t_r1 = 12'hFFF; t_r2 = 12'h123;
    v_int = 1; v_r1 = 1; v_r2 = 1;
    @(negedge mclk);
    v_int = 0; v_r1 = 0; v_r2 = 0;
    t_int = 12'h7FF; t_r1 = 12'h000; t_r2 = 12'hEDC;
    rdchk(4'h4, 16'h0800, "internal temp");
    rdchk(4'h5, 16'h0FFF, "remote1 temp");
    rdchk(4'h6, 16'h0123, "remote2 temp");
    // Port 3 needs four samples before its flag shows
    pulse(12'h849);
    pulse(12'h008);
    pulse(12'h008);
    idle(4);
    rdchk(4'h0, 16'h0804, "conv lo");
    rdchk(4'h1, 16'h0001, "conv hi");
    pulse(12'h008);
    idle(4);
    rdchk(4'h0, 16'h0824, "conv lo group");
    @(negedge mclk);
    oc_det = 12'h802;
    idle(8);
    oc_det = '0;
    rdchk(4'h2, 16'h0008, "oc lo");
    rdchk(4'h3, 16'h0001, "oc hi");
    chk("oc any", 16'h0001, {15'h0000, oc_any});
    // Status reads with no summary read must not clear
    rdchk(4'h1, 16'h0001, "conv hi kept");
    rdchk(4'h0, 16'h0824, "conv lo kept");
    chk("conv any", 16'h0001, {15'h0000, conv_any});
    u_evs_host.clear_pair(4'h0, 4'h1);
    rdchk(4'h0, 16'h0000, "conv lo clear");
    rdchk(4'h1, 16'h0000, "conv hi clear");
    chk("conv any clear", 16'h0000, {15'h0000, conv_any});
    rdchk(4'h2, 16'h0008, "oc lo kept");
    u_evs_host.clear_pair(4'h2, 4'h3);
    rdchk(4'h2, 16'h0000, "oc lo clear");
    rdchk(4'h3, 16'h0000, "oc hi clear");
    chk("oc any clear", 16'h0000, {15'h0000, oc_any});
    // Rising edges, then falling edges, against each edge code
    @(negedge mclk);
    pins = 12'h81F;
    idle(8);
    rdchk(4'h7, 16'h0028, "gpi lo rise");
    rdchk(4'h8, 16'h0001, "gpi hi rise");
    chk("gpi any", 16'h0001, {15'h0000, gpi_any});
    u_evs_host.clear_pair(4'h7, 4'h8);
    rdchk(4'h7, 16'h0000, "gpi lo clear");
    rdchk(4'h8, 16'h0000, "gpi hi clear");
    chk("gpi any clear", 16'h0000, {15'h0000, gpi_any});
    @(negedge mclk);
    pins = 12'h000;
    idle(8);
    rdchk(4'h7, 16'h0030, "gpi lo fall");
    rdchk(4'h8, 16'h0000, "gpi hi fall");
    wrap_up();
  end
endmodule

`default_nettype wire
